// ---- blcfg_consts.svh ----
`ifndef BLCFG_CONSTS_SVH
`define BLCFG_CONSTS_SVH
// target address and derived first bytes
`define BLCFG_TARGET_ADDR 7'h36
`define BLCFG_WRITE_BYTE 8'h6c
`define BLCFG_READ_BYTE 8'h6d
// register indices on the link
`define BLCFG_REG_ENABLE 8'h10
`define BLCFG_REG_MODE 8'h11
`define BLCFG_REG_FAULT 8'h1f
`define BLCFG_NUM_REGS 32
// fault register bit positions
`define BLCFG_FAULT_OC_BIT 1
`define BLCFG_FAULT_TH_BIT 2
// timing
`define BLCFG_CLK_MHZ 250
`define BLCFG_WINDOW_US 128
`define BLCFG_WINDOW_CYC (`BLCFG_WINDOW_US * `BLCFG_CLK_MHZ)
`define BLCFG_OC_MIN_EVENTS 2
`define BLCFG_OC_WINDOWS 32
// host apb register offsets
`define BLCFG_APB_CTRL 12'h000
`define BLCFG_APB_STATUS 12'h004
`define BLCFG_APB_IRQ_STAT 12'h008
`define BLCFG_APB_IRQ_MASK 12'h00c
`define BLCFG_APB_DIV 12'h010
// ctrl fields
`define BLCFG_CTRL_GO 0
`define BLCFG_CTRL_RD 1
`define BLCFG_CTRL_REG_LSB 8
`define BLCFG_CTRL_DATA_LSB 16
`define BLCFG_DIV_RESET 16'h0014
`endif

// ---- blcfg_pkg.sv ----
package blcfg_pkg;
  typedef enum logic [2:0] {
    BLCFG_D_IDLE, BLCFG_D_RECV, BLCFG_D_ACK, BLCFG_D_SEND, BLCFG_D_MACK
  } blcfg_dev_state_t;
  typedef enum logic [2:0] {
    BLCFG_H_IDLE, BLCFG_H_START, BLCFG_H_BIT, BLCFG_H_ACK, BLCFG_H_RSTART, BLCFG_H_STOP
  } blcfg_host_state_t;
endpackage

// ---- blcfg_if.sv ----
`timescale 1ns/1ps
interface blcfg_if;
  logic scl_o;
  logic scl_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  // open-drain wire level worked out by the bench from these
  logic scl_i;
  logic sda_i;
  modport device (input scl_i, input sda_i, output sda_dev_o, output sda_dev_oe);
  modport host (input scl_i, input sda_i, output scl_o, output scl_oe,
    output sda_host_o, output sda_host_oe);
endinterface

// ---- blcfg_device.sv ----
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - overcurrent cuts switch for rest of period
// - count overcurrent events per 128us window
// - fault bit after 32 windows with two+
// - overtemperature stops boost, sets thermal bit
// - boost restarts alone when die cools
// - start and stop detected while scl high
// - bus busy from start until stop
// - repeated start restarts address reception
// - host changes sda only while scl low
// - respond only to own 7-bit address
// - eighth bit selects write or read
// - write: register index then data byte
// - bytes eight bits, msb first
// - device pulls sda low on ninth pulse
// - change mode only with strings disabled (the device accepts a mode write whatever enable_reg holds)
`include "blcfg_consts.svh"
module blcfg_device
  import blcfg_pkg::*;
#(
  parameter int WINDOW_CYC = `BLCFG_WINDOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  blcfg_if.device link,
  input wire logic period_start,
  input wire logic oc_event,
  input wire logic over_temp,
  output logic switch_allow,
  output logic boost_enable,
  output logic bus_busy,
  output logic [7:0] enable_reg,
  output logic [7:0] mode_reg
);
  if (WINDOW_CYC < 4) begin : g_window_check
    $error("window too short");
  end

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    blcfg_dev_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] bytenum;
    logic rd;
    logic [7:0] index;
    logic sda_low;
    logic busy;
    logic [255:0] regs;
    logic oc_cut;
    logic [31:0] wcnt;
    logic [1:0] evcnt;
    logic [5:0] wins;
    logic oc_fault;
    logic th_fault;
    logic th_active;
  } blcfg_dev_t;

  blcfg_dev_t r, next_r;

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl = r.scl_s[1];
  assign sda = r.sda_s[1];
  assign scl_rise = scl & ~r.scl_q;
  assign scl_fall = ~scl & r.scl_q;
  assign start_c = scl & r.scl_q & r.sda_q & ~sda;
  assign stop_c = scl & r.scl_q & ~r.sda_q & sda;

  function automatic logic [7:0] rd_reg(input blcfg_dev_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = s.regs[idx[4:0]*8 +: 8];
    if (idx == `BLCFG_REG_FAULT) begin
      v[`BLCFG_FAULT_OC_BIT] = s.oc_fault;
      v[`BLCFG_FAULT_TH_BIT] = s.th_fault;
    end
    return v;
  endfunction

  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[0], link.scl_i};
    next_r.sda_s = {r.sda_s[0], link.sda_i};
    next_r.scl_q = scl;
    next_r.sda_q = sda;
    // ---- overcurrent: cut for rest of period, resume at next period
    if (oc_event) begin
      next_r.oc_cut = 1'b1;
    end else if (period_start) begin
      next_r.oc_cut = 1'b0;
    end
    // ---- pulse density qualifier
    if (r.wcnt == 32'(WINDOW_CYC - 1)) begin
      next_r.wcnt = '0;
      next_r.evcnt = '0;
      // an event in the window's last cycle still belongs to this window
      if (r.evcnt >= 2'(`BLCFG_OC_MIN_EVENTS)
          || (oc_event && r.evcnt == 2'(`BLCFG_OC_MIN_EVENTS - 1))) begin
        if (r.wins == 6'(`BLCFG_OC_WINDOWS - 1)) begin
          next_r.oc_fault = 1'b1;
        end else begin
          next_r.wins = r.wins + 6'd1;
        end
      end else begin
        next_r.wins = '0;
      end
    end else begin
      next_r.wcnt = r.wcnt + 32'd1;
      if (oc_event && r.evcnt != 2'd3) next_r.evcnt = r.evcnt + 2'd1;
    end
    // ---- thermal: detector hysteresis is analog, flag is sticky
    next_r.th_active = over_temp;
    if (over_temp) next_r.th_fault = 1'b1;
    // ---- link
    if (start_c) begin
      next_r.busy = 1'b1;
      next_r.st = BLCFG_D_RECV;
      next_r.bitcnt = '0;
      next_r.bytenum = '0;
      next_r.sda_low = 1'b0;
    end else if (stop_c) begin
      next_r.busy = 1'b0;
      next_r.st = BLCFG_D_IDLE;
      next_r.sda_low = 1'b0;
    end else begin
      case (r.st)
        BLCFG_D_RECV: begin
          if (scl_rise) begin
            next_r.shreg = {r.shreg[6:0], sda};
            next_r.bitcnt = r.bitcnt + 4'd1;
          end else if (scl_fall && r.bitcnt == 4'd8) begin
            next_r.bitcnt = '0;
            if (r.bytenum == 2'd0) begin
              if (r.shreg[7:1] == `BLCFG_TARGET_ADDR) begin
                next_r.rd = r.shreg[0];
                next_r.sda_low = 1'b1;
                next_r.st = BLCFG_D_ACK;
              end else begin
                next_r.st = BLCFG_D_IDLE;
              end
            end else begin
              if (r.bytenum == 2'd1) begin
                next_r.index = r.shreg;
              end else begin
                if (r.index[7:5] == 3'd0 && r.index != `BLCFG_REG_FAULT) begin
                  next_r.regs[r.index[4:0]*8 +: 8] = r.shreg;
                end
                next_r.index = r.index + 8'd1;
              end
              next_r.sda_low = 1'b1;
              next_r.st = BLCFG_D_ACK;
            end
          end
        end
        BLCFG_D_ACK: begin
          if (scl_fall) begin
            next_r.sda_low = 1'b0;
            if (r.bytenum != 2'd2) next_r.bytenum = r.bytenum + 2'd1;
            if (r.rd) begin
              next_r.shreg = rd_reg(r, r.index);
              next_r.sda_low = ~next_r.shreg[7];
              next_r.bitcnt = 4'd1;
              next_r.st = BLCFG_D_SEND;
            end else begin
              next_r.st = BLCFG_D_RECV;
            end
          end
        end
        BLCFG_D_SEND: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'd8) begin
              next_r.sda_low = 1'b0;
              next_r.st = BLCFG_D_MACK;
            end else begin
              next_r.sda_low = ~r.shreg[7 - 3'(r.bitcnt)];
              next_r.bitcnt = r.bitcnt + 4'd1;
            end
          end
        end
        BLCFG_D_MACK: begin
          if (scl_rise) begin
            if (sda) begin
              next_r.st = BLCFG_D_IDLE;
            end else begin
              next_r.index = r.index + 8'd1;
              next_r.st = BLCFG_D_ACK;
            end
          end
        end
        default: next_r.st = BLCFG_D_IDLE;
      endcase
    end
    // reading the fault register clears the thermal flag only with over_temp low and the oc flag only with wins at zero
    if (r.th_fault && !over_temp && r.st == BLCFG_D_MACK && scl_rise
        && r.index == `BLCFG_REG_FAULT) begin
      next_r.th_fault = 1'b0;
    end
    if (r.oc_fault && r.st == BLCFG_D_MACK && scl_rise
        && r.index == `BLCFG_REG_FAULT && r.wins == 6'd0) begin
      next_r.oc_fault = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{scl_s: 2'b11, sda_s: 2'b11, scl_q: 1'b1, sda_q: 1'b1, st: BLCFG_D_IDLE,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = r.sda_low;
  assign switch_allow = ~r.oc_cut & ~r.th_active;
  assign boost_enable = ~r.th_active;
  assign bus_busy = r.busy;
  assign enable_reg = r.regs[`BLCFG_REG_ENABLE*8 +: 8];
  assign mode_reg = r.regs[`BLCFG_REG_MODE*8 +: 8];
endmodule

// ---- blcfg_host.sv ----
`timescale 1ns/1ps
`include "blcfg_consts.svh"
module blcfg_host
  import blcfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  blcfg_if.host link
);
  typedef struct packed {
    logic [1:0] sda_s;
    blcfg_host_state_t st;
    logic [15:0] div;
    logic [15:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitcnt;
    logic [1:0] byten;
    logic [7:0] sh;
    logic rd;
    logic [7:0] reg_idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic nack;
    logic scl;
    logic sda;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
  } blcfg_host_r_t;

  blcfg_host_r_t r, next_r;
  logic tick, sda_in, wr;
  assign sda_in = r.sda_s[1];
  assign tick = r.cnt == r.div;
  assign wr = psel & penable & pwrite;

  always_comb begin
    next_r = r;
    next_r.sda_s = {r.sda_s[0], link.sda_i};
    next_r.cnt = tick ? 16'd0 : r.cnt + 16'd1;
    // ---- apb registers
    if (wr) begin
      case (paddr)
        `BLCFG_APB_CTRL: begin
          if (pwdata[`BLCFG_CTRL_GO] && r.st == BLCFG_H_IDLE) begin
            next_r.rd = pwdata[`BLCFG_CTRL_RD];
            next_r.reg_idx = pwdata[`BLCFG_CTRL_REG_LSB +: 8];
            next_r.wdata = pwdata[`BLCFG_CTRL_DATA_LSB +: 8];
            next_r.st = BLCFG_H_START;
            next_r.ph = '0;
            next_r.byten = '0;
          end
        end
        `BLCFG_APB_IRQ_MASK: next_r.irq_mask = pwdata[1:0];
        `BLCFG_APB_DIV: next_r.div = (pwdata[15:0] < 16'd4) ? 16'd4 : pwdata[15:0];
        default: ;
      endcase
    end
    case (paddr)
      `BLCFG_APB_STATUS: next_r.prdata = {22'd0, r.nack, r.st != BLCFG_H_IDLE, r.rdata};
      `BLCFG_APB_IRQ_STAT: next_r.prdata = {30'd0, r.irq_stat};
      `BLCFG_APB_IRQ_MASK: next_r.prdata = {30'd0, r.irq_mask};
      `BLCFG_APB_DIV: next_r.prdata = {16'd0, r.div};
      default: next_r.prdata = '0;
    endcase
    if (wr && paddr == `BLCFG_APB_IRQ_STAT) next_r.irq_stat = r.irq_stat & ~pwdata[1:0];
    // ---- link sequencer, four phases per bit
    if (tick) begin
      next_r.ph = r.ph + 2'd1;
      case (r.st)
        BLCFG_H_START, BLCFG_H_RSTART: begin
          // sda high, scl high, sda low, scl low
          case (r.ph)
            2'd0: next_r.sda = 1'b1;
            2'd1: next_r.scl = 1'b1;
            2'd2: next_r.sda = 1'b0;
            default: begin
              next_r.scl = 1'b0;
              next_r.sh = (r.st == BLCFG_H_RSTART) ? `BLCFG_READ_BYTE : `BLCFG_WRITE_BYTE;
              next_r.bitcnt = '0;
              next_r.st = BLCFG_H_BIT;
            end
          endcase
        end
        BLCFG_H_BIT: begin
          case (r.ph)
            2'd0: next_r.sda = (r.byten == 2'd3) ? 1'b1 : r.sh[7];
            2'd1: next_r.scl = 1'b1;
            2'd2: if (r.byten == 2'd3) next_r.rdata = {r.rdata[6:0], sda_in};
            default: begin
              next_r.scl = 1'b0;
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.bitcnt = r.bitcnt + 4'd1;
              if (r.bitcnt == 4'd7) next_r.st = BLCFG_H_ACK;
            end
          endcase
        end
        BLCFG_H_ACK: begin
          case (r.ph)
            2'd0: next_r.sda = 1'b1;
            2'd1: next_r.scl = 1'b1;
            2'd2: if (r.byten != 2'd3 && sda_in) next_r.nack = 1'b1;
            default: begin
              next_r.scl = 1'b0;
              next_r.bitcnt = '0;
              if (r.nack || r.byten == 2'd3 || (r.byten == 2'd2 && !r.rd)) begin
                next_r.st = BLCFG_H_STOP;
              end else if (r.byten == 2'd1 && r.rd) begin
                next_r.st = BLCFG_H_RSTART;
                // byte 2 is the read address, still shifted out; data follows as byte 3
                next_r.byten = 2'd2;
              end else begin
                next_r.byten = r.byten + 2'd1;
                next_r.sh = (r.byten == 2'd0) ? r.reg_idx : r.wdata;
                next_r.st = BLCFG_H_BIT;
              end
            end
          endcase
        end
        BLCFG_H_STOP: begin
          case (r.ph)
            2'd0: next_r.sda = 1'b0;
            2'd1: next_r.scl = 1'b1;
            2'd2: next_r.sda = 1'b1;
            default: begin
              next_r.st = BLCFG_H_IDLE;
              next_r.irq_stat[0] = 1'b1;
              if (r.nack) next_r.irq_stat[1] = 1'b1;
            end
          endcase
        end
        default: next_r.ph = '0;
      endcase
    end
    if (r.st == BLCFG_H_START && r.ph == 2'd0) next_r.nack = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{sda_s: 2'b11, st: BLCFG_H_IDLE, div: `BLCFG_DIV_RESET, scl: 1'b1, sda: 1'b1,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~r.scl;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = ~r.sda;
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(r.irq_stat & ~r.irq_mask);
endmodule

// ---- blcfg_chk.sv ----
`timescale 1ns/1ps
module blcfg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_oe,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  // ==========
  // bus state seen on the wire
  logic busy;
  logic scl_q;
  logic sda_q;
  logic start_w;
  logic stop_w;
  assign start_w = scl_i && scl_q && sda_q && !sda_i;
  assign stop_w = scl_i && scl_q && !sda_q && sda_i;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      busy <= start_w ? 1'b1 : (stop_w ? 1'b0 : busy);
    end
  end
  // ==========
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dev_sda_steady: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_dev_oe)) else $error("device moved sda in scl high");
  a_host_sda_steady: assert property (
    scl_i && $past(scl_i) && $changed(sda_host_oe) |-> start_w || stop_w)
    else $error("host moved sda in scl high");
  a_scl_high_min: assert property (
    $rose(scl_i) |-> scl_i [*8]) else $error("scl high phase too short");
  a_scl_low_max: assert property (
    $fell(scl_i) |-> ##[1:1000] scl_i) else $error("scl held low too long");
  a_start_by_host: assert property (
    start_w |-> $rose(sda_host_oe)) else $error("start not made by host");
  a_stop_by_host: assert property (
    stop_w |-> $fell(sda_host_oe) && !sda_dev_oe) else $error("stop not made by host");
  a_dev_quiet_free: assert property (
    !busy |-> !sda_dev_oe) else $error("device drives a free bus");
  a_ack_hold: assert property (
    $rose(sda_dev_oe) |-> sda_dev_oe [*8]) else $error("device pull too short");
  a_idle_reset: assert property (
    !$past(presetn) |-> !scl_oe && !sda_host_oe && !sda_dev_oe) else $error("lines held at reset");
  c_start: cover property (start_w);
  c_ack: cover property ($rose(sda_dev_oe));
  c_stop: cover property (stop_w);
endmodule

// ---- i2c_config_port_with_fault_flags_tb.sv ----
`timescale 1ns/1ps
`include "blcfg_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t: got %0h want %0h", $time, g, e); end end
module i2c_config_port_with_fault_flags_tb
  import blcfg_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] st;
  logic pready, pslverr, irq, switch_allow, boost_enable, bus_busy;
  logic period_start = 1'b0;
  logic oc_event = 1'b0;
  logic over_temp = 1'b0;
  logic [7:0] enable_reg, mode_reg;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  blcfg_if link();
  // open-drain resolution: any enable pulls the wire low
  assign link.scl_i = !link.scl_oe;
  assign link.sda_i = !(link.sda_dev_oe || link.sda_host_oe);
  blcfg_host i_blcfg_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  blcfg_device #(.WINDOW_CYC(16)) i_blcfg_device (.pclk(pclk), .presetn(presetn), .link(link),
    .period_start(period_start), .oc_event(oc_event), .over_temp(over_temp),
    .switch_allow(switch_allow), .boost_enable(boost_enable), .bus_busy(bus_busy),
    .enable_reg(enable_reg), .mode_reg(mode_reg));
  blcfg_chk i_blcfg_chk (.pclk(pclk), .presetn(presetn), .scl_oe(link.scl_oe),
    .sda_dev_oe(link.sda_dev_oe), .sda_host_oe(link.sda_host_oe), .scl_i(link.scl_i),
    .sda_i(link.sda_i));
  // ==========
  // clock, timeout, verdict
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // bus tasks
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link transfer; st holds the final status word
  task op(input logic r, input logic [7:0] ix, input logic [7:0] d);
    int n;
    apb(1'b1, `BLCFG_APB_IRQ_STAT, 32'h0000_0003, rd);
    apb(1'b1, `BLCFG_APB_CTRL, {8'h00, d, ix, 6'h00, r, 1'b1}, rd);
    n = 0;
    while (bus_busy !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    `CHK(bus_busy, 1'b1)
    n = 0;
    do begin
      apb(1'b0, `BLCFG_APB_IRQ_STAT, 32'h0000_0000, rd);
      n++;
    end while (rd[0] !== 1'b1 && n < 3000);
    `CHK(rd[0], 1'b1)
    apb(1'b0, `BLCFG_APB_STATUS, 32'h0000_0000, st);
    `CHK(st[9], 1'b0)
    `CHK(bus_busy, 1'b0)
  endtask
  task pulse_oc(input int gap);
    @(posedge pclk) oc_event <= 1'b1;
    @(posedge pclk) oc_event <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  // ==========
  // scenarios
  task t_regs;
    op(1'b0, `BLCFG_REG_ENABLE, 8'h01);
    `CHK(enable_reg, 8'h01)
    op(1'b0, `BLCFG_REG_MODE, 8'h60);
    `CHK(mode_reg, 8'h60)
    op(1'b1, `BLCFG_REG_MODE, 8'h00);
    `CHK(st[7:0], 8'h60)
  endtask
  task t_oc_cut;
    `CHK(switch_allow, 1'b1)
    pulse_oc(1);
    #1 `CHK(switch_allow, 1'b0)
    @(posedge pclk) period_start <= 1'b1;
    @(posedge pclk) period_start <= 1'b0;
    #1 `CHK(switch_allow, 1'b1)
  endtask
  task t_oc_fault;
    // one event per window never qualifies
    repeat (40) pulse_oc(14);
    // a quiet window in between restarts the run of dense windows
    repeat (80) pulse_oc(2);
    repeat (32) @(posedge pclk);
    repeat (80) pulse_oc(2);
    op(1'b1, `BLCFG_REG_FAULT, 8'h00);
    `CHK(st[1], 1'b0)
    repeat (160) pulse_oc(2);
    op(1'b1, `BLCFG_REG_FAULT, 8'h00);
    `CHK(st[1], 1'b1)
  endtask
  task t_thermal;
    @(posedge pclk) over_temp <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(boost_enable, 1'b0)
    op(1'b1, `BLCFG_REG_FAULT, 8'h00);
    `CHK(st[2], 1'b1)
    @(posedge pclk) over_temp <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(boost_enable, 1'b1)
  endtask
  task t_irq;
    apb(1'b1, `BLCFG_APB_IRQ_MASK, 32'h0000_0003, rd);
    op(1'b0, `BLCFG_REG_ENABLE, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, `BLCFG_APB_IRQ_MASK, 32'h0000_0000, rd);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, `BLCFG_APB_IRQ_STAT, 32'h0000_0001, rd);
    apb(1'b0, `BLCFG_APB_IRQ_STAT, 32'h0000_0000, rd);
    `CHK(rd[0], 1'b0)
    `CHK(irq, 1'b0)
    apb(1'b0, 12'h020, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(pslverr, 1'b0)
    // fastest legal link clock: divider is clamped to four
    apb(1'b1, `BLCFG_APB_DIV, 32'h0000_0002, rd);
    apb(1'b0, `BLCFG_APB_DIV, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0004)
    op(1'b0, `BLCFG_REG_ENABLE, 8'h03);
    `CHK(enable_reg, 8'h03)
    op(1'b1, `BLCFG_REG_ENABLE, 8'h00);
    `CHK(st[7:0], 8'h03)
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_oc_cut();
    t_oc_fault();
    t_thermal();
    t_irq();
    end_of_test();
  end
endmodule
